// ### inc/adc_regs_pkg.sv
`default_nettype none
package adc_regs_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] ADDR_RESULT_HIGH = 4'h0;
   localparam logic [3:0] ADDR_RESULT_LOW = 4'h1;
   localparam logic [3:0] ADDR_CMP_HIGH = 4'h2;
   localparam logic [3:0] ADDR_CMP_LOW = 4'h3;
   localparam logic [3:0] ADDR_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_PIN_SEL_LOW = 4'h5;
   localparam logic [3:0] ADDR_STATUS_CTRL = 4'h6;
   localparam logic [3:0] ADDR_CMP_CTRL = 4'h7;
   // Configuration field positions
   localparam int CFG_LOW_POWER_BIT = 7;
   localparam int CFG_DIV_LSB = 5;
   localparam int CFG_LONG_SAMPLE_BIT = 4;
   localparam int CFG_MODE_LSB = 2;
   localparam int CFG_CLK_LSB = 0;
   // Status/control field positions
   localparam int SC_FLAG_BIT = 7;
   localparam int CC_ACTIVE_BIT = 7;
   localparam int CC_CMP_EN_BIT = 5;
   localparam int CC_CMP_GT_BIT = 4;
   // Reset values and the value read at unmapped offsets
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] PIN_SEL_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'h00;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // Resolution codes
   localparam logic [1:0] MODE_8 = 2'h0;
   localparam logic [1:0] MODE_12 = 2'h1;
   localparam logic [1:0] MODE_10 = 2'h2;
   // Input clock codes
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_HALF = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;
   typedef enum logic [1:0] {
      LOCK_OPEN = 2'b01,
      LOCK_HELD = 2'b10
   } lock_state_t;
endpackage
`default_nettype wire

// ### verilog/adc_result_compare_config.sv
`timescale 1ns/1ps
`default_nettype none
module adc_result_compare_config (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic conv_done_in,
   input wire logic [11:0] conv_result_in,
   input wire logic conv_active_in,
   input wire logic alt_clk_in,
   input wire logic async_clk_in,
   input wire logic [7:0] port_out_in,
   input wire logic [7:0] port_oe_in,
   input wire logic [7:0] port_pullup_in,
   input wire logic [7:0] pin_level_in,
   output logic converter_clock_out,
   output logic low_power_select_out,
   output logic long_sample_select_out,
   output logic [1:0] resolution_mode_out,
   output logic start_write_out,
   output logic conversion_complete_flag_out,
   output logic [7:0] pin_out_out,
   output logic [7:0] pin_oe_out,
   output logic [7:0] pin_pullup_out,
   output logic [7:0] port_read_out
);

   typedef struct packed {
      logic [7:0] rdata;
      logic [11:0] result;
      logic [7:0] cmp_high;
      logic [7:0] cmp_low;
      logic [7:0] config_reg;
      logic [1:0] clk_sel_live;
      logic [1:0] div_live;
      logic [7:0] pin_sel;
      logic cmp_en;
      logic cmp_gt;
      adc_regs_pkg::lock_state_t lock;
      logic flag;
      logic start_wr;
      logic bus_half;
      logic [2:0] div_cnt;
      logic src_d;
      logic conv_clk;
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
      logic [7:0] pin_pullup;
      logic [7:0] port_read;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic rst_sync1_r;
   logic rst_sync2_r;

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
      end
      else
      begin
         rst_sync1_r <= 1'b1;
         rst_sync2_r <= rst_sync1_r;
      end
   end

   logic [1:0] mode;
   logic [11:0] cmp_value;
   logic [11:0] diff;
   logic [11:0] masked_res;
   logic cmp_true;
   logic store_ok;
   logic src_clk;
   logic src_edge;
   logic [2:0] div_mask;
   logic [11:0] clean_diff;

   always_comb
   begin
      mode = s_r.config_reg[adc_regs_pkg::CFG_MODE_LSB +: 2];
      // Compare value width follows the resolution
      case (mode)
         adc_regs_pkg::MODE_12: cmp_value = {s_r.cmp_high[3:0], s_r.cmp_low};
         adc_regs_pkg::MODE_10: cmp_value = {2'b00, s_r.cmp_high[1:0], s_r.cmp_low};
         default: cmp_value = {4'h0, s_r.cmp_low};
      endcase
      case (mode)
         adc_regs_pkg::MODE_12: masked_res = conv_result_in;
         adc_regs_pkg::MODE_10: masked_res = {2'b00, conv_result_in[9:0]};
         default: masked_res = {4'h0, conv_result_in[7:0]};
      endcase
      cmp_true = s_r.cmp_gt ? (masked_res >= cmp_value) : (masked_res < cmp_value);
      diff = masked_res + (~cmp_value + 12'h001);
      case (mode)
         adc_regs_pkg::MODE_12: clean_diff = diff;
         adc_regs_pkg::MODE_10: clean_diff = {2'b00, diff[9:0]};
         default: clean_diff = {4'h0, diff[7:0]};
      endcase
      // 8-bit mode never holds the lock
      store_ok = (s_r.lock == adc_regs_pkg::LOCK_OPEN) || (mode == adc_regs_pkg::MODE_8);
      case (s_r.clk_sel_live)
         adc_regs_pkg::CLK_BUS: src_clk = 1'b1;
         adc_regs_pkg::CLK_BUS_HALF: src_clk = s_r.bus_half;
         adc_regs_pkg::CLK_ALT: src_clk = alt_clk_in;
         default: src_clk = async_clk_in;
      endcase
      src_edge = (s_r.clk_sel_live == adc_regs_pkg::CLK_BUS) ? 1'b1 : (src_clk & ~s_r.src_d);
      // Half-period in source edges: ratio 2 -> 1, 4 -> 2, 8 -> 4
      case (s_r.div_live)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h0;
         2'h2: div_mask = 3'h1;
         default: div_mask = 3'h3;
      endcase

      s_nxt = s_r;
      s_nxt.start_wr = 1'b0;
      s_nxt.bus_half = ~s_r.bus_half;
      s_nxt.src_d = src_clk;
      if (!conv_active_in)
      begin
         s_nxt.clk_sel_live = s_r.config_reg[adc_regs_pkg::CFG_CLK_LSB +: 2];
         s_nxt.div_live = s_r.config_reg[adc_regs_pkg::CFG_DIV_LSB +: 2];
      end
      // Ratio one follows the sampled source; on the bus clock a register
      // can at best toggle each cycle, so that case gives half the bus rate
      if ((s_r.div_live == 2'h0) && (s_r.clk_sel_live != adc_regs_pkg::CLK_BUS))
      begin
         s_nxt.div_cnt = 3'h0;
         s_nxt.conv_clk = src_clk;
      end
      else if (src_edge)
      begin
         if ((s_r.div_cnt & div_mask) == div_mask)
         begin
            s_nxt.div_cnt = 3'h0;
            s_nxt.conv_clk = ~s_r.conv_clk;
         end
         else
         begin
            s_nxt.div_cnt = s_r.div_cnt + 3'h1;
         end
      end

      s_nxt.rdata = adc_regs_pkg::READ_UNMAPPED;
      if (rd_in)
      begin
         case (addr_in)
            adc_regs_pkg::ADDR_RESULT_HIGH:
            begin
               s_nxt.rdata = {4'h0, s_r.result[11:8]};
               if (mode != adc_regs_pkg::MODE_8)
                  s_nxt.lock = adc_regs_pkg::LOCK_HELD;
            end
            adc_regs_pkg::ADDR_RESULT_LOW:
            begin
               s_nxt.rdata = s_r.result[7:0];
               s_nxt.lock = adc_regs_pkg::LOCK_OPEN;
               s_nxt.flag = 1'b0;
            end
            adc_regs_pkg::ADDR_CMP_HIGH: s_nxt.rdata = s_r.cmp_high;
            adc_regs_pkg::ADDR_CMP_LOW: s_nxt.rdata = s_r.cmp_low;
            adc_regs_pkg::ADDR_CONFIG: s_nxt.rdata = s_r.config_reg;
            adc_regs_pkg::ADDR_PIN_SEL_LOW: s_nxt.rdata = s_r.pin_sel;
            adc_regs_pkg::ADDR_STATUS_CTRL: s_nxt.rdata = {s_r.flag, 7'h00};
            adc_regs_pkg::ADDR_CMP_CTRL:
               s_nxt.rdata = {conv_active_in, 1'b0, s_r.cmp_en, s_r.cmp_gt, 4'h0};
            default: s_nxt.rdata = adc_regs_pkg::READ_UNMAPPED;
         endcase
      end
      if (wr_in)
      begin
         case (addr_in)
            adc_regs_pkg::ADDR_CMP_HIGH: s_nxt.cmp_high = wdata_in;
            adc_regs_pkg::ADDR_CMP_LOW: s_nxt.cmp_low = wdata_in;
            adc_regs_pkg::ADDR_CONFIG: s_nxt.config_reg = wdata_in;
            adc_regs_pkg::ADDR_PIN_SEL_LOW: s_nxt.pin_sel = wdata_in;
            adc_regs_pkg::ADDR_STATUS_CTRL:
            begin
               s_nxt.flag = 1'b0;
               s_nxt.start_wr = 1'b1;
            end
            adc_regs_pkg::ADDR_CMP_CTRL:
            begin
               s_nxt.cmp_en = wdata_in[adc_regs_pkg::CC_CMP_EN_BIT];
               s_nxt.cmp_gt = wdata_in[adc_regs_pkg::CC_CMP_GT_BIT];
            end
            default: s_nxt.start_wr = 1'b0;
         endcase
      end
      // Completion after the clear sources so a new result wins
      if (conv_done_in && store_ok && (!s_r.cmp_en || cmp_true))
      begin
         s_nxt.result = s_r.cmp_en ? clean_diff : masked_res;
         s_nxt.flag = 1'b1;
      end

      for (int i = 0; i < 8; i++)
      begin
         s_nxt.pin_out[i] = s_r.pin_sel[i] ? 1'b0 : port_out_in[i];
         s_nxt.pin_oe[i] = s_r.pin_sel[i] ? 1'b0 : port_oe_in[i];
         s_nxt.pin_pullup[i] = s_r.pin_sel[i] ? 1'b0 : port_pullup_in[i];
         s_nxt.port_read[i] = s_r.pin_sel[i] ? 1'b0 : pin_level_in[i];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_sync2_r)
   begin
      if (!rst_sync2_r)
      begin
         s_r <= '0;
         s_r.lock <= adc_regs_pkg::LOCK_OPEN;
         s_r.config_reg <= adc_regs_pkg::CONFIG_RESET;
         s_r.pin_sel <= adc_regs_pkg::PIN_SEL_RESET;
         s_r.cmp_high <= adc_regs_pkg::CMP_RESET;
         s_r.cmp_low <= adc_regs_pkg::CMP_RESET;
         s_r.result <= adc_regs_pkg::RESULT_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign rdata_out = s_r.rdata;
   assign converter_clock_out = s_r.conv_clk;
   assign low_power_select_out = s_r.config_reg[adc_regs_pkg::CFG_LOW_POWER_BIT];
   assign long_sample_select_out = s_r.config_reg[adc_regs_pkg::CFG_LONG_SAMPLE_BIT];
   assign resolution_mode_out = s_r.config_reg[adc_regs_pkg::CFG_MODE_LSB +: 2];
   assign start_write_out = s_r.start_wr;
   assign conversion_complete_flag_out = s_r.flag;
   assign pin_out_out = s_r.pin_out;
   assign pin_oe_out = s_r.pin_oe;
   assign pin_pullup_out = s_r.pin_pullup;
   assign port_read_out = s_r.port_read;

endmodule
`default_nettype wire

// ### tb/adc_result_compare_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_chk (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic conv_done_in,
   input wire logic [7:0] port_oe_in,
   input wire logic [7:0] port_pullup_in,
   input wire logic low_power_select_out,
   input wire logic long_sample_select_out,
   input wire logic [1:0] resolution_mode_out,
   input wire logic conversion_complete_flag_out,
   input wire logic [7:0] pin_oe_out,
   input wire logic [7:0] pin_pullup_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_hi;
      rd_in && addr_in == adc_regs_pkg::ADDR_RESULT_HIGH |=> rdata_out[7:4] == 4'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("high byte upper nibble set");
   property p_cfg;
      rd_in && addr_in == adc_regs_pkg::ADDR_CONFIG |=> {rdata_out[7], rdata_out[4:2]} ==
         {low_power_select_out, long_sample_select_out, resolution_mode_out};
   endproperty
   a_cfg: assert property (p_cfg) else $error("config outputs differ");
   property p_clr_w;
      wr_in && addr_in == adc_regs_pkg::ADDR_STATUS_CTRL && !conv_done_in ##1 !conv_done_in
         |=> !conversion_complete_flag_out;
   endproperty
   a_clr_w: assert property (p_clr_w) else $error("flag kept after write");
   property p_clr_r;
      rd_in && addr_in == adc_regs_pkg::ADDR_RESULT_LOW && !conv_done_in ##1 !conv_done_in
         |=> !conversion_complete_flag_out;
   endproperty
   a_clr_r: assert property (p_clr_r) else $error("flag kept after low read");
   property p_set;
      $rose(conversion_complete_flag_out) |-> $past(conv_done_in) || $past(conv_done_in, 2);
   endproperty
   a_set: assert property (p_set) else $error("flag set without completion");
   property p_oe;
      (pin_oe_out & ~$past(port_oe_in)) == 8'h00;
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable without request");
   property p_pu;
      (pin_pullup_out & ~$past(port_pullup_in)) == 8'h00;
   endproperty
   a_pu: assert property (p_pu) else $error("pullup without request");
   property p_sel;
      rd_in && addr_in == adc_regs_pkg::ADDR_PIN_SEL_LOW |=> (rdata_out & pin_oe_out) == 8'h00;
   endproperty
   a_sel: assert property (p_sel) else $error("released pin still driven");
endmodule
bind adc_result_compare_config adc_chk u_adc_chk (.*);
`default_nettype wire

// ### tb/adc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic slow_in,
   input wire logic [11:0] value_in,
   output logic active_out = 1'b0,
   output logic done_out = 1'b0,
   output logic [11:0] result_out
);
   int cnt_r = 0;
   always @(posedge clk_in)
   begin
      done_out <= cnt_r == 1;
      active_out <= cnt_r > 1 || start_in;
      if (start_in)
         cnt_r <= slow_in ? 24 : 3;
      else if (cnt_r > 0)
         cnt_r <= cnt_r - 1;
   end
   // Result lines carry a value only beside the completion pulse
   assign result_out = done_out ? value_in : ~value_in;
endmodule
`default_nettype wire

// ### tb/adc_result_compare_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_result_compare_config_tb;
   typedef struct packed {
      logic [7:0] cfg;
      logic [7:0] ctl;
      logic [11:0] cmp;
      logic [11:0] raw;
      logic [16:0] exp;
   } row_t;
   row_t rows [8] = '{'{8'h05, 8'h00, 12'h000, 12'habc, 17'h1_0abc},
      '{8'h9a, 8'h00, 12'h000, 12'hfff, 17'h1_03ff}, '{8'h73, 8'h00, 12'h000, 12'hf5a, 17'h1_005a},
      '{8'h84, 8'h30, 12'h100, 12'h345, 17'h1_0245}, '{8'h84, 8'h20, 12'h100, 12'h345, 17'h0_0245},
      '{8'h28, 8'h30, 12'hc00, 12'h010, 17'h1_0010}, '{8'h50, 8'h30, 12'hf20, 12'h035, 17'h1_0015},
      '{8'h04, 8'h20, 12'h0ff, 12'h0fe, 17'h1_0fff}};
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic slow = 1'b0;
   logic b;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wdata_in = 8'h00;
   logic [7:0] pv = 8'hff;
   logic [11:0] val = 12'h000;
   logic [7:0] rdata_out, pin_out_out, pin_oe_out, pin_pullup_out, port_read_out;
   logic [11:0] conv_result_in;
   logic [1:0] resolution_mode_out;
   logic conv_done_in, conv_active_in, converter_clock_out, low_power_select_out;
   logic long_sample_select_out, start_write_out, conversion_complete_flag_out;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int k;
   adc_result_compare_config u_adc_result_compare_config (.ref_clk_in, .rst_n_in, .addr_in,
      .wdata_in, .wr_in, .rd_in, .rdata_out, .conv_done_in, .conv_result_in, .conv_active_in,
      .alt_clk_in(cyc[3]), .async_clk_in(cyc[2]), .port_out_in(pv), .port_oe_in(pv),
      .port_pullup_in(pv), .pin_level_in(pv), .converter_clock_out, .low_power_select_out,
      .long_sample_select_out, .resolution_mode_out, .start_write_out,
      .conversion_complete_flag_out, .pin_out_out, .pin_oe_out, .pin_pullup_out, .port_read_out);
   adc_core_model u_adc_core_model (.clk_in(ref_clk_in), .start_in(start_write_out),
      .slow_in(slow), .value_in(val), .active_out(conv_active_in), .done_out(conv_done_in),
      .result_out(conv_result_in));
   initial forever #50 ref_clk_in = ~ref_clk_in;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
   endtask
   task cv(input logic [11:0] r);
      val <= r;
      wr(adc_regs_pkg::ADDR_STATUS_CTRL, 8'h00);
      for (k = 0; k < 40 && conv_done_in !== 1'b1; k++)
         #100;
      #200;
   endtask
   task end_sim;
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors++;
         end_sim();
      end
   end
   initial
   begin
      repeat (16) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      rd(adc_regs_pkg::ADDR_CONFIG, 8'h00);
      rd(adc_regs_pkg::ADDR_PIN_SEL_LOW, 8'h00);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         slow <= i[0];
         wr(adc_regs_pkg::ADDR_CONFIG, rows[i].cfg);
         wr(adc_regs_pkg::ADDR_CMP_CTRL, rows[i].ctl);
         wr(adc_regs_pkg::ADDR_CMP_HIGH, {4'h0, rows[i].cmp[11:8]});
         wr(adc_regs_pkg::ADDR_CMP_LOW, rows[i].cmp[7:0]);
         cv(rows[i].raw);
         chk({low_power_select_out, long_sample_select_out, resolution_mode_out},
            {rows[i].cfg[7], rows[i].cfg[4:2]});
         chk(conversion_complete_flag_out, rows[i].exp[16]);
         rd(adc_regs_pkg::ADDR_RESULT_HIGH, rows[i].exp[15:8]);
         rd(adc_regs_pkg::ADDR_RESULT_LOW, rows[i].exp[7:0]);
      end
      rd(adc_regs_pkg::ADDR_CMP_LOW, 8'hff);
      rd(adc_regs_pkg::ADDR_CMP_CTRL, 8'h20);
      wr(adc_regs_pkg::ADDR_CMP_CTRL, 8'h00);
      wr(adc_regs_pkg::ADDR_CONFIG, 8'h04);
      cv(12'h123);
      rd(adc_regs_pkg::ADDR_RESULT_HIGH, 8'h01);
      cv(12'h456);
      rd(adc_regs_pkg::ADDR_RESULT_LOW, 8'h23);
      rd(adc_regs_pkg::ADDR_RESULT_HIGH, 8'h01);
      cv(12'h789);
      rd(adc_regs_pkg::ADDR_RESULT_LOW, 8'h23);
      wr(adc_regs_pkg::ADDR_CONFIG, 8'h00);
      cv(12'h0ab);
      rd(adc_regs_pkg::ADDR_RESULT_HIGH, 8'h00);
      cv(12'h0cd);
      rd(adc_regs_pkg::ADDR_RESULT_LOW, 8'hcd);
      wr(adc_regs_pkg::ADDR_PIN_SEL_LOW, 8'h0f);
      pv <= 8'h5a;
      #200;
      chk({pin_out_out, pin_oe_out}, 16'h5050);
      chk({pin_pullup_out, port_read_out}, 16'h5050);
      rd(adc_regs_pkg::ADDR_PIN_SEL_LOW, 8'h0f);
      // Reset in mid-run: outputs cleared, registers back to reset values
      rst_n_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      chk({pin_oe_out, pin_pullup_out}, 16'h0000);
      chk({rdata_out, 3'h0, conversion_complete_flag_out, resolution_mode_out, 2'h0}, 16'h0000);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      #1;
      rd(adc_regs_pkg::ADDR_PIN_SEL_LOW, 8'h00);
      rd(adc_regs_pkg::ADDR_CONFIG, 8'h00);
      for (int d = 1; d < 4; d++)
      begin
         wr(adc_regs_pkg::ADDR_CONFIG, {1'b0, d[1:0], 5'h00});
         #1000;
         k = 0;
         repeat (64)
         begin
            b = converter_clock_out;
            #100;
            k += int'(b === 1'b0 && converter_clock_out === 1'b1);
         end
         chk(k[15:0], 16'(64 >> d));
      end
      end_sim();
   end
endmodule
`default_nettype wire
